/* inc/mio_flash_regs.svh */
`ifndef MIO_FLASH_REGS_SVH
`define MIO_FLASH_REGS_SVH

// Read opcodes served by the device.
`define OP_DUAL_IO_READ 8'hbb
`define OP_DUAL_IO_READ_4B 8'hbc
`define OP_QUAD_IO_READ 8'heb
`define OP_QUAD_IO_READ_4B 8'hec

// Bit counts of each phase; a phase lasts its bit count shifted right by the width code.
`define INSTR_BITS 6'h08
`define ADDR3_BITS 6'h18
`define ADDR4_BITS 6'h20
`define MODE_BITS 6'h08
`define BYTE_BITS 6'h08
`define MODE_CONT_NIBBLE 4'ha
`define MODE_CONT_BYTE 8'ha0

// Mode cycles the host still drives before releasing the lines.
`define DUAL_MODE_DRIVEN 6'h02
`define QUAD_MODE_DRIVEN 6'h01

// Serial clock timing.
`define SCK_MAX_MHZ 133
`define SYS_CLK_MHZ 25
`define SCK_HALF_CYCLES 8

// Controller register offsets (byte addresses) and fields.
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_CFG 8'h08
`define REG_STATUS 8'h0c
`define REG_DATA 8'h10
`define CTRL_GO 0
`define CTRL_QUAD 1
`define CTRL_ADDR4 2
`define CTRL_SKIP_INSTR 3
`define CTRL_QUAD_INSTR 4
`define CTRL_CONT 5
`define CFG_DUMMY_LSB 16

`endif

/* inc/mio_flash_pkg.sv */
package mio_flash_pkg;

  typedef enum logic [1:0] {W_ONE = 2'b00, W_TWO = 2'b01, W_FOUR = 2'b10} width_t;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_CMD = 3'b001, D_ADDR = 3'b010, D_MODE = 3'b011,
    D_DUMMY = 3'b100, D_DATA = 3'b101, D_IGNORE = 3'b110
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_CMD = 3'b001, H_ADDR = 3'b010, H_MODE = 3'b011,
    H_DUMMY = 3'b100, H_DATA = 3'b101, H_END = 3'b110
  } host_state_t;

  // Upper bits of a byte placed on the data lines, highest bit on the highest line.
  function automatic logic [3:0] place_io(input logic [7:0] b, input width_t w);
    case (w)
      W_FOUR: place_io = b[7:4];
      W_TWO: place_io = {2'b00, b[7:6]};
      default: place_io = {3'b000, b[7]};
    endcase
  endfunction : place_io

  function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [3:0] io, input width_t w);
    case (w)
      W_FOUR: shift_in = {s[27:0], io};
      W_TWO: shift_in = {s[29:0], io[1:0]};
      default: shift_in = {s[30:0], io[0]};
    endcase
  endfunction : shift_in

  function automatic logic [3:0] lane_mask(input width_t w);
    case (w)
      W_FOUR: lane_mask = 4'hf;
      W_TWO: lane_mask = 4'h3;
      default: lane_mask = 4'h1;
    endcase
  endfunction : lane_mask

endpackage : mio_flash_pkg

/* inc/flash_link_if.sv */
`timescale 1ns/1ns
interface flash_link_if;
  logic sck;
  logic cs_n;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // Undriven lines float high through a weak pull-up.
  genvar i;
  for (i = 0; i < 4; i++) begin : g_line
    assign io[i] = host_io_oe[i] ? host_io_o[i] : (dev_io_oe[i] ? dev_io_o[i] : 1'b1);
  end

  modport host (output sck, output cs_n, output host_io_o, output host_io_oe, input io);
  modport device (input sck, input cs_n, input io, output dev_io_o, output dev_io_oe);
endinterface : flash_link_if

/* hw/sync2.sv */
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule : sync2

/* hw/flash_mio_read_dev.sv */
`timescale 1ns/1ns
// Contract
// - Dual opcode address length: bit, or four bytes.
// - Quad opcode address length: bit, or four bytes.
// - Dual address and data two bits per clock.
// - Dual: instruction, address, four mode cycles, latency.
// - Mode Axh: next dual access skips instruction.
// - Only upper mode nibble decides continuation.
// - Other dual mode, or mode reset: leave.
// - Dummy count from latency code; lines ignored.
// - Dual data driven on falling clock edges.
// - Address increments per byte, wraps to zero.
// - Host releases lines before first data edge.
// - Host keeps select low through mode, dummy.
// - Quad read only with quad enable set.
// - Quad address and data four bits per clock.
// - Quad mode takes two cycles, then dummies.
// - Quad mode Axh: next access skips instruction.
// - Other quad mode value: leave at select rise.
// - Host may release quad lines in last mode.
// - Quad instruction mode: instruction four bits wide.
// - Host keeps serial clock under maximum rate.
`include "mio_flash_regs.svh"
module flash_mio_read_dev
  import mio_flash_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  flash_link_if.device link,
  input wire logic i_address_length_bit,
  input wire logic [3:0] i_latency_code_field,
  input wire logic i_quad_instruction_mode_bit,
  input wire logic i_quad_enable_bit,
  input wire logic i_mode_reset,
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  output logic o_cont_read
);

  if (ADDR_W < 1 || ADDR_W > 24) begin : g_bad_addr_w
    $error("ADDR_W must lie between 1 and 24");
  end

  logic [7:0] mem [0:(1<<ADDR_W)-1];

  // Clock, select and data lines cross into the system clock domain.
  logic [5:0] s_q;
  logic cs_n_s;
  logic sck_s;
  logic [3:0] io_s;

  // Select crosses inverted so that the synchroniser's reset value reads as deselected.
  sync2 #(.W(6)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_d({~link.cs_n, link.sck, link.io}),
    .o_q(s_q)
  );

  assign cs_n_s = ~s_q[5];
  assign sck_s = s_q[4];
  assign io_s = s_q[3:0];

  logic sck_prev_q;
  logic cs_prev_q;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_n_s;
    end
  end

  assign rise = sck_s & ~sck_prev_q & ~cs_n_s;
  assign fall = ~sck_s & sck_prev_q & ~cs_n_s;
  assign cs_fall = ~cs_n_s & cs_prev_q;
  assign cs_rise = cs_n_s & ~cs_prev_q;

  dev_state_t st_q;
  width_t w_q;
  logic [5:0] cnt_q;
  logic [5:0] tgt;
  logic last;
  logic quad_q;
  logic a4_q;
  logic cont_q;
  logic cont_quad_q;
  logic [31:0] sh_q;
  logic [31:0] sh_d;
  logic [31:0] addr_full;
  logic [7:0] opc;
  logic dual_ok;
  logic quad_ok;
  logic to_data;

  assign sh_d = shift_in(sh_q, io_s, w_q);
  assign opc = sh_d[7:0];
  assign addr_full = a4_q ? sh_d : {8'h00, sh_d[23:0]};

  // Dual opcodes are not taken while instructions arrive four bits wide.
  assign dual_ok = ~i_quad_instruction_mode_bit &
                   (opc == `OP_DUAL_IO_READ || opc == `OP_DUAL_IO_READ_4B);
  assign quad_ok = i_quad_enable_bit & (opc == `OP_QUAD_IO_READ || opc == `OP_QUAD_IO_READ_4B);

  always_comb begin
    case (st_q)
      D_CMD: tgt = `INSTR_BITS >> w_q;
      D_ADDR: tgt = (a4_q ? `ADDR4_BITS : `ADDR3_BITS) >> w_q;
      D_MODE: tgt = `MODE_BITS >> w_q;
      D_DUMMY: tgt = {2'b00, i_latency_code_field};
      default: tgt = 6'h01;
    endcase
  end

  assign last = (cnt_q + 6'h01) == tgt;
  assign to_data = rise & last &
                   ((st_q == D_MODE && i_latency_code_field == 4'h0) || st_q == D_DUMMY);

  // Phase sequencing, counted on rising serial clock edges.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_q <= D_IDLE;
      cnt_q <= 6'h00;
      w_q <= W_ONE;
      quad_q <= 1'b0;
      a4_q <= 1'b0;
    end else if (cs_rise) begin
      st_q <= D_IDLE;
    end else if (cs_fall) begin
      cnt_q <= 6'h00;
      if (cont_q) begin
        st_q <= D_ADDR;
        w_q <= cont_quad_q ? W_FOUR : W_TWO;
        quad_q <= cont_quad_q;
      end else begin
        st_q <= D_CMD;
        w_q <= i_quad_instruction_mode_bit ? W_FOUR : W_ONE;
      end
    end else if (rise) begin
      cnt_q <= last ? 6'h00 : cnt_q + 6'h01;
      if (last) begin
        case (st_q)
          D_CMD: begin
            a4_q <= i_address_length_bit | opc == `OP_DUAL_IO_READ_4B | opc == `OP_QUAD_IO_READ_4B;
            if (dual_ok) begin
              st_q <= D_ADDR;
              w_q <= W_TWO;
              quad_q <= 1'b0;
            end else if (quad_ok) begin
              st_q <= D_ADDR;
              w_q <= W_FOUR;
              quad_q <= 1'b1;
            end else begin
              st_q <= D_IGNORE;
            end
          end
          D_ADDR: st_q <= D_MODE;
          D_MODE: st_q <= (i_latency_code_field == 4'h0) ? D_DATA : D_DUMMY;
          D_DUMMY: st_q <= D_DATA;
          default: st_q <= st_q;
        endcase
      end
    end
  end

  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_nx;
  logic [3:0] mode_hi_q;
  logic mode_done_q;
  logic [7:0] out_q;
  logic [5:0] piece_q;
  logic piece_last;

  assign addr_nx = addr_q + 1'b1;
  assign piece_last = (piece_q + 6'h01) == (`BYTE_BITS >> w_q);

  // Input shifting, mode capture and the outgoing byte.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sh_q <= 32'h0000_0000;
      addr_q <= '0;
      mode_hi_q <= 4'h0;
      mode_done_q <= 1'b0;
      out_q <= 8'h00;
      piece_q <= 6'h00;
    end else if (cs_fall) begin
      sh_q <= 32'h0000_0000;
      mode_done_q <= 1'b0;
    end else if (rise && (st_q == D_CMD || st_q == D_ADDR || st_q == D_MODE)) begin
      sh_q <= sh_d;
      if (last && st_q == D_ADDR) begin
        addr_q <= addr_full[ADDR_W-1:0];
      end
      if (last && st_q == D_MODE) begin
        mode_hi_q <= sh_d[7:4];
        mode_done_q <= 1'b1;
      end
      if (to_data) begin
        out_q <= mem[addr_q];
        piece_q <= 6'h00;
      end
    end else if (to_data) begin
      out_q <= mem[addr_q];
      piece_q <= 6'h00;
    end else if (fall && st_q == D_DATA) begin
      if (piece_last) begin
        addr_q <= addr_nx;
        out_q <= mem[addr_nx];
        piece_q <= 6'h00;
      end else begin
        out_q <= out_q << (3'h1 << w_q);
        piece_q <= piece_q + 6'h01;
      end
    end
  end

  // Data lines are driven only from the first data falling edge until select rises.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      link.dev_io_o <= 4'h0;
      link.dev_io_oe <= 4'h0;
    end else if (cs_rise) begin
      link.dev_io_oe <= 4'h0;
    end else if (fall && st_q == D_DATA) begin
      link.dev_io_o <= place_io(out_q, w_q);
      link.dev_io_oe <= lane_mask(w_q);
    end
  end

  // Continuation is settled when select rises; the mode reset input clears it.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cont_q <= 1'b0;
      cont_quad_q <= 1'b0;
    end else if (cs_rise) begin
      cont_q <= mode_done_q && mode_hi_q == `MODE_CONT_NIBBLE;
      cont_quad_q <= quad_q;
    end else if (i_mode_reset) begin
      cont_q <= 1'b0;
    end
  end

  assign o_cont_read = cont_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

endmodule : flash_mio_read_dev

/* hw/flash_mio_read_host.sv */
`timescale 1ns/1ns
`include "mio_flash_regs.svh"
module flash_mio_read_host
  import mio_flash_pkg::*;
#(
  parameter int SCK_HALF = `SCK_HALF_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  flash_link_if.host link,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata
);

  // Each serial edge must outlast the far end's synchroniser and the return path.
  if (SCK_HALF < 8 || SCK_HALF > 255 || `SYS_CLK_MHZ > 2 * SCK_HALF * `SCK_MAX_MHZ) begin : g_bad_half
    $error("SCK_HALF out of range");
  end

  logic [3:0] io_s;
  sync2 #(.W(4)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_d(link.io),
    .o_q(io_s)
  );

  host_state_t st_q;
  logic accept;
  logic wr_q;
  logic [7:0] wa_q;
  logic start;
  logic [31:0] addr_q;
  logic [15:0] len_q;
  logic [3:0] dummy_q;
  logic [7:0] data_q;
  logic full_q;
  logic byte_done;

  assign accept = i_hsel & i_htrans[1] & i_hready;
  assign start = wr_q && wa_q == `REG_CTRL && i_hwdata[`CTRL_GO] && st_q == H_IDLE && len_q != 16'h0000;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      o_hrdata <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      wr_q <= accept & i_hwrite;
      wa_q <= i_haddr[7:0];
      if (accept && !i_hwrite) begin
        case (i_haddr[7:0])
          `REG_ADDR: o_hrdata <= addr_q;
          `REG_CFG: o_hrdata <= {12'h000, dummy_q, len_q};
          `REG_STATUS: o_hrdata <= {30'h0000_0000, full_q, st_q != H_IDLE};
          `REG_DATA: o_hrdata <= {24'h00_0000, data_q};
          default: o_hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      addr_q <= 32'h0000_0000;
      len_q <= 16'h0001;
      dummy_q <= 4'h0;
    end else if (wr_q && wa_q == `REG_ADDR) begin
      addr_q <= i_hwdata;
    end else if (wr_q && wa_q == `REG_CFG) begin
      len_q <= i_hwdata[15:0];
      dummy_q <= i_hwdata[`CFG_DUMMY_LSB +: 4];
    end
  end

  // A new byte sets the flag in the same cycle as a read of DATA would clear it.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      full_q <= 1'b0;
    end else if (byte_done) begin
      full_q <= 1'b1;
    end else if (accept && !i_hwrite && i_haddr[7:0] == `REG_DATA) begin
      full_q <= 1'b0;
    end
  end

  width_t w_q;
  logic quad_q;
  logic a4_q;
  logic cont_q;
  logic sck_q;
  logic run;
  logic tick;
  logic [7:0] div_q;
  logic [5:0] cnt_q;
  logic [5:0] tgt;
  logic last;
  logic ld_q;
  logic [31:0] sh_q;
  logic [31:0] sh_n;
  logic [31:0] rx_d;
  logic [15:0] left_q;
  logic [31:0] addr_sh;

  // The clock stops low before a rise while an unread byte is waiting.
  assign run = st_q != H_IDLE && !(st_q == H_DATA && full_q && !sck_q);
  assign tick = run && div_q == 8'(SCK_HALF - 1);
  assign rx_d = shift_in({24'h00_0000, data_q}, io_s, w_q);
  assign byte_done = tick && !sck_q && st_q == H_DATA && last;
  assign addr_sh = a4_q ? addr_q : {addr_q[23:0], 8'h00};
  assign sh_n = ld_q ? (st_q == H_ADDR ? addr_sh : {cont_q ? `MODE_CONT_BYTE : 8'h00, 24'h00_0000})
                     : sh_q << (3'h1 << w_q);

  always_comb begin
    case (st_q)
      H_CMD: tgt = `INSTR_BITS >> w_q;
      H_ADDR: tgt = (a4_q ? `ADDR4_BITS : `ADDR3_BITS) >> w_q;
      H_MODE: tgt = `MODE_BITS >> w_q;
      H_DUMMY: tgt = {2'h0, dummy_q};
      H_DATA: tgt = `BYTE_BITS >> w_q;
      default: tgt = 6'h01;
    endcase
  end

  assign last = (cnt_q + 6'h01) == tgt;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_q <= 8'h00;
    end else if (!run || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_q <= H_IDLE;
      w_q <= W_ONE;
      quad_q <= 1'b0;
      a4_q <= 1'b0;
      cont_q <= 1'b0;
      sck_q <= 1'b0;
      cnt_q <= 6'h00;
      ld_q <= 1'b0;
      sh_q <= 32'h0000_0000;
      left_q <= 16'h0000;
      data_q <= 8'h00;
      link.sck <= 1'b0;
      link.cs_n <= 1'b1;
      link.host_io_o <= 4'h0;
      link.host_io_oe <= 4'h0;
    end else if (start) begin
      quad_q <= i_hwdata[`CTRL_QUAD];
      a4_q <= i_hwdata[`CTRL_ADDR4];
      cont_q <= i_hwdata[`CTRL_CONT];
      left_q <= len_q;
      cnt_q <= 6'h00;
      ld_q <= 1'b0;
      link.cs_n <= 1'b0;
      if (i_hwdata[`CTRL_SKIP_INSTR]) begin
        st_q <= H_ADDR;
        w_q <= i_hwdata[`CTRL_QUAD] ? W_FOUR : W_TWO;
        sh_q <= i_hwdata[`CTRL_ADDR4] ? addr_q : {addr_q[23:0], 8'h00};
        link.host_io_o <= place_io(i_hwdata[`CTRL_ADDR4] ? addr_q[31:24] : addr_q[23:16],
                                   i_hwdata[`CTRL_QUAD] ? W_FOUR : W_TWO);
        link.host_io_oe <= i_hwdata[`CTRL_QUAD] ? 4'hf : 4'h3;
      end else begin
        st_q <= H_CMD;
        w_q <= i_hwdata[`CTRL_QUAD_INSTR] ? W_FOUR : W_ONE;
        sh_q <= {i_hwdata[15:8], 24'h00_0000};
        link.host_io_o <= place_io(i_hwdata[15:8], i_hwdata[`CTRL_QUAD_INSTR] ? W_FOUR : W_ONE);
        link.host_io_oe <= i_hwdata[`CTRL_QUAD_INSTR] ? 4'hf : 4'h1;
      end
    end else if (tick && !sck_q) begin
      sck_q <= 1'b1;
      link.sck <= 1'b1;
      cnt_q <= last ? 6'h00 : cnt_q + 6'h01;
      if (st_q == H_DATA) begin
        data_q <= rx_d[7:0];
        if (last) begin
          left_q <= left_q - 16'h0001;
          st_q <= (left_q == 16'h0001) ? H_END : H_DATA;
        end
      end else if (last) begin
        case (st_q)
          H_CMD: begin
            st_q <= H_ADDR;
            w_q <= quad_q ? W_FOUR : W_TWO;
            ld_q <= 1'b1;
          end
          H_ADDR: begin
            st_q <= H_MODE;
            ld_q <= 1'b1;
          end
          H_MODE: st_q <= (dummy_q == 4'h0) ? H_DATA : H_DUMMY;
          H_DUMMY: st_q <= H_DATA;
          default: st_q <= st_q;
        endcase
      end
    end else if (tick && sck_q) begin
      sck_q <= 1'b0;
      link.sck <= 1'b0;
      ld_q <= 1'b0;
      if (st_q == H_END) begin
        st_q <= H_IDLE;
        link.cs_n <= 1'b1;
        link.host_io_oe <= 4'h0;
      end else begin
        sh_q <= sh_n;
        link.host_io_o <= place_io(sh_n[31:24], w_q);
        if (st_q == H_CMD || st_q == H_ADDR) begin
          link.host_io_oe <= lane_mask(w_q);
        end else if (st_q == H_MODE && !ld_q &&
                     cnt_q >= (quad_q ? `QUAD_MODE_DRIVEN : `DUAL_MODE_DRIVEN)) begin
          link.host_io_oe <= 4'h0;
        end else if (st_q == H_MODE) begin
          link.host_io_oe <= lane_mask(w_q);
        end else begin
          link.host_io_oe <= 4'h0;
        end
      end
    end
  end

endmodule : flash_mio_read_host

/* verif/flash_mio_read_props.sv */
`timescale 1ns/1ns
module flash_mio_read_props #(
  parameter int SCK_HALF = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  logic [7:0] hi_q;
  // Counts the sampled cycles of each high phase of the serial clock.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hi_q <= 8'h00;
    end else begin
      hi_q <= sck ? hi_q + 8'h01 : 8'h00;
    end
  end
  chk_sck_high_len: assert property ($fell(sck) |-> hi_q == 8'(SCK_HALF))
    else $error("sck high phase length wrong");
  chk_no_contention: assert property ((host_io_oe & dev_io_oe) == 4'h0)
    else $error("host and device drive one line");
  chk_select_setup: assert property ($fell(cs_n) |-> !sck [*8])
    else $error("sck rose too soon after select");
  chk_idle_clock_low: assert property (cs_n |-> !sck)
    else $error("sck high while deselected");
  chk_dev_on_fall: assert property ($changed(dev_io_o) && dev_io_oe != 4'h0 |-> !sck)
    else $error("device data changed while sck high");
  chk_dev_lane_set: assert property (dev_io_oe inside {4'h0, 4'h3, 4'hf})
    else $error("device drives an odd set of lines");
  chk_lines_released: assert property ($rose(cs_n) |-> ##[1:8] io == 4'hf)
    else $error("lines not released after deselect");
  chk_host_on_fall: assert property ($changed(host_io_o) |-> !sck)
    else $error("host data changed while sck high");
  cover property ($fell(cs_n));
  cover property (dev_io_oe == 4'h3);
  cover property (dev_io_oe == 4'hf);
endmodule : flash_mio_read_props

/* verif/multi_io_flash_read_bench.sv */
`timescale 1ns/1ns
`include "mio_flash_regs.svh"
module multi_io_flash_read_bench;
  logic clk_sys;
  logic rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic alen;
  logic [3:0] lat;
  logic qim;
  logic qen;
  logic mode_rst;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic cont_read;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  flash_link_if link();
  flash_mio_read_host #(.SCK_HALF(8)) flash_mio_read_host_inst (.i_clk_sys(clk_sys), .i_rst(rst), .link(link),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata));
  flash_mio_read_dev #(.ADDR_W(8)) flash_mio_read_dev_inst (.i_clk_sys(clk_sys), .i_rst(rst), .link(link),
    .i_address_length_bit(alen), .i_latency_code_field(lat), .i_quad_instruction_mode_bit(qim),
    .i_quad_enable_bit(qen), .i_mode_reset(mode_rst), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .o_cont_read(cont_read));
  flash_mio_read_props #(.SCK_HALF(8)) flash_mio_read_props_inst (.i_clk_sys(clk_sys), .i_rst(rst),
    .sck(link.sck), .cs_n(link.cs_n), .host_io_o(link.host_io_o), .host_io_oe(link.host_io_oe),
    .dev_io_o(link.dev_io_o), .dev_io_oe(link.dev_io_oe), .io(link.io));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end
  function automatic logic [7:0] pat(input logic [7:0] a);
    pat = {a[3:0], a[7:4]} ^ 8'h3c;
  endfunction : pat
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error: %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus
  task automatic reset_dut();
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
  endtask : reset_dut
  // Runs one read frame; a refused frame leaves the pulled-up lines, so every byte reads ffh.
  task automatic rd_seq(input string name, input logic [15:0] ctrl, input logic [31:0] a, input int n,
                        input logic [3:0] dm, input logic ok, input logic cont_exp);
    logic [31:0] rd;
    lat <= dm;
    bus(1'b1, `REG_CFG, {12'h0, dm, 16'(n)}, rd);
    bus(1'b1, `REG_ADDR, a, rd);
    bus(1'b0, `REG_CFG, 32'h0, rd);
    check({name, " cfg"}, rd, {12'h0, dm, 16'(n)});
    bus(1'b0, `REG_ADDR, 32'h0, rd);
    check({name, " addr"}, rd, a);
    bus(1'b1, `REG_CTRL, {16'h0, ctrl | 16'h0001}, rd);
    for (int i = 0; i < n; i++) begin
      rd = 32'h0;
      while (rd[1] !== 1'b1) bus(1'b0, `REG_STATUS, 32'h0, rd);
      bus(1'b0, `REG_DATA, 32'h0, rd);
      check({name, " data"}, {24'h0, rd[7:0]}, ok ? {24'h0, pat(a[7:0] + 8'(i))} : 32'hff);
    end
    rd = 32'h1;
    while (rd[0] !== 1'b0) bus(1'b0, `REG_STATUS, 32'h0, rd);
    repeat (8) @(posedge clk_sys);
    check({name, " cont"}, {31'h0, cont_read}, {31'h0, cont_exp});
    $display("test %s done", name);
  endtask : rd_seq
  initial begin
    logic [31:0] rd;
    {hsel, hwrite, wr_en, alen, qim, qen, mode_rst, htrans, lat, wr_addr, wr_data, haddr, hwdata} <= '0;
    reset_dut();
    for (int i = 0; i < 256; i++) begin
      wr_en <= 1'b1;
      wr_addr <= 8'(i);
      wr_data <= pat(8'(i));
      @(posedge clk_sys);
    end
    wr_en <= 1'b0;
    bus(1'b0, 8'h14, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    rd_seq("dual3", 16'hbb00, 32'h0000_00fe, 4, 4'h0, 1'b1, 1'b0);
    rd_seq("dual4op", 16'hbc04, 32'h1234_5610, 2, 4'h2, 1'b1, 1'b0);
    alen <= 1'b1;
    rd_seq("dual4bit", 16'hbb04, 32'h0000_0033, 2, 4'h1, 1'b1, 1'b0);
    alen <= 1'b0;
    rd_seq("dual_arm", 16'hbb20, 32'h0000_0050, 1, 4'h0, 1'b1, 1'b1);
    rd_seq("dual_skip", 16'h0008, 32'h0000_0040, 2, 4'h0, 1'b1, 1'b0);
    rd_seq("quad_off", 16'heb02, 32'h0000_0020, 1, 4'h0, 1'b0, 1'b0);
    qen <= 1'b1;
    rd_seq("quad3", 16'heb02, 32'h0000_00fe, 3, 4'h3, 1'b1, 1'b0);
    rd_seq("quad4", 16'hec06, 32'h0000_0081, 2, 4'h0, 1'b1, 1'b0);
    rd_seq("quad_arm", 16'heb22, 32'h0000_0007, 1, 4'h1, 1'b1, 1'b1);
    rd_seq("quad_skip", 16'h000a, 32'h0000_0090, 2, 4'h1, 1'b1, 1'b0);
    qim <= 1'b1;
    rd_seq("wide_instr", 16'heb12, 32'h0000_00a5, 2, 4'h2, 1'b1, 1'b0);
    rd_seq("wide_dual", 16'hbb00, 32'h0000_00a5, 1, 4'h0, 1'b0, 1'b0);
    qim <= 1'b0;
    rd_seq("mrst_arm", 16'hbb20, 32'h0000_0001, 1, 4'h0, 1'b1, 1'b1);
    mode_rst <= 1'b1;
    @(posedge clk_sys);
    mode_rst <= 1'b0;
    @(posedge clk_sys);
    check("mode reset", {31'h0, cont_read}, 32'h0);
    rd_seq("rst_arm", 16'heb22, 32'h0000_0011, 1, 4'h0, 1'b1, 1'b1);
    reset_dut();
    @(posedge clk_sys);
    check("reset", {31'h0, cont_read}, 32'h0);
    rd_seq("after_rst", 16'h000a, 32'h0000_0000, 1, 4'h0, 1'b0, 1'b0);
    wrap_up();
  end
endmodule : multi_io_flash_read_bench
